// ### pmcb_bank.v
// Purpose: manufacturer command bank of a four-channel power system manager
// Assumes: a bus front end presents decoded command reads and writes, synchronous to mclk
// Notes: signed linear words are compared in value, not as raw bits
//
// Behaviour
// - unsigned linear output voltage is mantissa times two to the minus thirteen
// - peak trackers keep largest output voltage and temperature per page, input voltage for all pages
// - minimum trackers keep smallest output voltage and temperature per page, input voltage for all pages
// - retry interval word, non-paged, default 200 ms encoding
// - restart delay word, non-paged, default 400 ms encoding
// - save command copies fault record from RAM to nonvolatile store
// - reload command copies saved fault record back to RAM
// - wipe command initialises fault record store and releases logging lock
// - fault record is read as a sequence of bytes
// - channel selector picks paged channel, resets to zero
// - global page mask defaults to all four channels
// - bus address base byte defaults to 5C
// - write lock level byte defaults to zero, no protection
// - per-page temperature gain word defaults to unity
// - per-page read-only current sense voltage magnitude
// - per-page off threshold coefficient defaults to 2.0
// - first and later watchdog intervals, default zero
// - power-good assertion delay, default 100 ms encoding
// - retry limit byte, default zero
// - per-page trim converter code, ten bits, resets to zero
// - per-page temperature offset, default zero
// - fixed read-only part identifier word
// - selector values zero to three address channels zero to three
// - each mask bit sets its channel's global_write_en bit while the global page is selected
`include "pmcb_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module pmcb_bank #(
   parameter [15:0] PART_ID = `PMCB_PART_ID_DEFAULT // arbitrary value
) (
   input wire mclk,
   input wire arst_n,
   input wire cmd_wr,
   input wire cmd_rd,
   input wire [7:0] cmd_code,
   input wire [15:0] cmd_wdata,
   input wire wp_pin,
   output reg [15:0] cmd_rdata,
   output reg cmd_ack,
   output reg cmd_err,
   input wire meas_vld,
   input wire [1:0] meas_chan,
   input wire [15:0] meas_vout,
   input wire [15:0] meas_temp,
   input wire [15:0] meas_isense,
   input wire vin_vld,
   input wire [15:0] meas_vin,
   input wire [15:0] pad_in,
   input wire [7:0] lot_code,
   input wire [7:0] common_status,
   input wire [7:0] log_rdata,
   output wire [7:0] log_raddr,
   output reg log_save,
   output reg log_reload,
   output reg log_wipe,
   input wire log_busy,
   input wire log_locked,
   output wire [1:0] page_sel,
   output wire page_global,
   output wire [3:0] global_write_en,
   output wire [6:0] bus_addr_base,
   output wire [15:0] retry_interval,
   output wire [15:0] restart_delay,
   output wire [15:0] pgood_delay,
   output wire [15:0] wdog_first,
   output wire [15:0] wdog_later,
   output wire [7:0] retry_limit,
   output wire [7:0] config_three
);
   reg [7:0] page_r, wlock_r, cfg3_r, rlimit_r;
   reg [15:0] retry_r, restart_r, pgood_r, wdf_r, wdl_r, pads_r;
   reg [3:0] mask_r;
   reg [6:0] base_r;
   reg [7:0] log_ptr_r;
   reg [15:0] vin_max_r, vin_min_r;
   reg [15:0] trim_r [0:3];
   reg [15:0] coeff_r [0:3];
   reg [15:0] tgain_r [0:3];
   reg [15:0] toff_r [0:3];
   reg [15:0] vmax_r [0:3];
   reg [15:0] vmin_r [0:3];
   reg [15:0] tmax_r [0:3];
   reg [15:0] tmin_r [0:3];
   reg [15:0] isense_r [0:3], tc_r [0:3];
   wire page_ok;
   wire lock_one;
   wire lock_two;
   wire wr_allow;
   wire paged_cmd;
   wire [1:0] pg;
   reg [15:0] rd_nxt;
   reg rd_bad;

   // signed linear value compare: a < b ; mantissa shifted by exponent
   function slin_lt;
      input [15:0] a;
      input [15:0] b;
      reg signed [47:0] va, vb;
      begin
         va = $signed({{37{a[10]}}, a[10:0]}) <<< ($signed(a[15:11]) + 16);
         vb = $signed({{37{b[10]}}, b[10:0]}) <<< ($signed(b[15:11]) + 16);
         slin_lt = va < vb;
      end
   endfunction

   assign pg = page_r[1:0];
   assign page_ok = (page_r <= `PMCB_PAGE_LAST);
   assign page_global = (page_r == `PMCB_PAGE_GLOBAL);
   assign page_sel = pg;
   assign global_write_en = page_global ? mask_r : 4'h0;
   // the stricter of pin and command level wins
   assign lock_one = (wlock_r == `PMCB_LOCK_LEVEL_ONE);
   assign lock_two = (wlock_r == `PMCB_LOCK_LEVEL_TWO) | wp_pin;
   assign wr_allow = (cmd_code == `PMCB_CMD_WRITE_LOCK_LEVEL) ||
                     (cmd_code == `PMCB_CMD_CHANNEL_SELECT) ||
                     (!lock_one && (!lock_two || cmd_code == `PMCB_CMD_GLOBAL_PAGE_MASK));
   assign paged_cmd = (cmd_code == `PMCB_CMD_TRIM_CONVERTER_CODE) ||
                      (cmd_code == `PMCB_CMD_OFF_THRESHOLD_COEFF) ||
                      (cmd_code == `PMCB_CMD_CURRENT_GAIN_TEMPCO) ||
                      (cmd_code == `PMCB_CMD_EXT_TEMP_GAIN) ||
                      (cmd_code == `PMCB_CMD_EXT_TEMP_OFFSET);
   assign bus_addr_base = base_r;
   assign retry_interval = retry_r;
   assign restart_delay = restart_r;
   assign pgood_delay = pgood_r;
   assign wdog_first = wdf_r;
   assign wdog_later = wdl_r;
   assign retry_limit = rlimit_r;
   assign config_three = cfg3_r;
   assign log_raddr = log_ptr_r;

   // non-paged writable commands; paged ones are steered by the selector
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         page_r <= `PMCB_RST_CHANNEL_SELECT;
         wlock_r <= `PMCB_RST_WRITE_LOCK_LEVEL;
         cfg3_r <= `PMCB_RST_CHANNEL_CONFIG_THREE;
         retry_r <= `PMCB_RST_FAULT_RETRY_INTERVAL;
         restart_r <= `PMCB_RST_CONTROL_RESTART_DELAY;
         pgood_r <= `PMCB_RST_PGOOD_ASSERT_DELAY;
         wdf_r <= `PMCB_RST_WDOG_FIRST_INTERVAL;
         wdl_r <= `PMCB_RST_WDOG_INTERVAL;
         mask_r <= `PMCB_RST_GLOBAL_PAGE_MASK;
         base_r <= `PMCB_RST_BUS_ADDRESS_BASE;
         rlimit_r <= `PMCB_RST_FAULT_RETRY_LIMIT;
         pads_r <= 16'h0000;
      end else begin
         pads_r <= pad_in;
         if (cmd_wr && wr_allow) begin
            case (cmd_code)
               `PMCB_CMD_CHANNEL_SELECT: page_r <= cmd_wdata[7:0];
               `PMCB_CMD_WRITE_LOCK_LEVEL: wlock_r <= cmd_wdata[7:0];
               `PMCB_CMD_CHANNEL_CONFIG_THREE: cfg3_r <= cmd_wdata[7:0];
               `PMCB_CMD_FAULT_RETRY_INTERVAL: retry_r <= cmd_wdata;
               `PMCB_CMD_CONTROL_RESTART_DELAY: restart_r <= cmd_wdata;
               `PMCB_CMD_PGOOD_ASSERT_DELAY: pgood_r <= cmd_wdata;
               `PMCB_CMD_WDOG_FIRST_INTERVAL: wdf_r <= cmd_wdata;
               `PMCB_CMD_WDOG_INTERVAL: wdl_r <= cmd_wdata;
               `PMCB_CMD_GLOBAL_PAGE_MASK: mask_r <= cmd_wdata[3:0];
               `PMCB_CMD_BUS_ADDRESS_BASE: base_r <= cmd_wdata[6:0];
               `PMCB_CMD_FAULT_RETRY_LIMIT: rlimit_r <= cmd_wdata[7:0];
               default: ;
            endcase
         end
      end
   end

   // per-channel storage and trackers, one copy per channel
   genvar c;
   generate
      for (c = 0; c < 4; c = c + 1) begin : g_chan
         wire sel_w;
         wire hit_w;
         assign sel_w = cmd_wr && wr_allow && page_ok && (pg == c);
         assign hit_w = meas_vld && (meas_chan == c);
         always @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
               trim_r[c] <= `PMCB_RST_TRIM_CONVERTER_CODE;
               coeff_r[c] <= `PMCB_RST_OFF_THRESHOLD_COEFF;
               tgain_r[c] <= `PMCB_RST_EXT_TEMP_GAIN;
               toff_r[c] <= `PMCB_RST_EXT_TEMP_OFFSET;
               vmax_r[c] <= `PMCB_RST_MAX_TRACK;
               vmin_r[c] <= `PMCB_RST_MIN_TRACK;
               tmax_r[c] <= `PMCB_RST_SLIN_MAX;
               tmin_r[c] <= `PMCB_RST_SLIN_MIN;
               isense_r[c] <= 16'h0000;
               tc_r[c] <= `PMCB_RST_CURRENT_GAIN_TEMPCO;
            end else begin
               if (sel_w && cmd_code == `PMCB_CMD_TRIM_CONVERTER_CODE)
                  trim_r[c] <= cmd_wdata & `PMCB_TRIM_CODE_MASK;
               if (sel_w && cmd_code == `PMCB_CMD_OFF_THRESHOLD_COEFF)
                  coeff_r[c] <= cmd_wdata;
               if (sel_w && cmd_code == `PMCB_CMD_EXT_TEMP_GAIN)
                  tgain_r[c] <= cmd_wdata;
               if (sel_w && cmd_code == `PMCB_CMD_EXT_TEMP_OFFSET)
                  toff_r[c] <= cmd_wdata;
               if (sel_w && cmd_code == `PMCB_CMD_CURRENT_GAIN_TEMPCO)
                  tc_r[c] <= cmd_wdata;
               if (hit_w) begin
                  isense_r[c] <= meas_isense;
                  // output voltage is unsigned linear, raw compare suffices
                  if (meas_vout > vmax_r[c]) vmax_r[c] <= meas_vout;
                  if (meas_vout < vmin_r[c]) vmin_r[c] <= meas_vout;
                  if (slin_lt(tmax_r[c], meas_temp)) tmax_r[c] <= meas_temp;
                  if (slin_lt(meas_temp, tmin_r[c])) tmin_r[c] <= meas_temp;
               end
            end
         end
      end
   endgenerate

   // input voltage trackers are not paged
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         vin_max_r <= `PMCB_RST_SLIN_MAX;
         vin_min_r <= `PMCB_RST_SLIN_MIN;
      end else if (vin_vld) begin
         if (slin_lt(vin_max_r, meas_vin)) vin_max_r <= meas_vin;
         if (slin_lt(meas_vin, vin_min_r)) vin_min_r <= meas_vin;
      end
   end

   // fault record commands: one-cycle strobes to the store engine
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         log_save <= 1'b0;
         log_reload <= 1'b0;
         log_wipe <= 1'b0;
         log_ptr_r <= 8'h00;
      end else begin
         log_save <= cmd_wr && wr_allow && !log_busy &&
                     cmd_code == `PMCB_CMD_FAULT_RECORD_SAVE;
         log_reload <= cmd_wr && wr_allow && !log_busy &&
                       cmd_code == `PMCB_CMD_FAULT_RECORD_RELOAD;
         log_wipe <= cmd_wr && wr_allow && !log_busy &&
                     cmd_code == `PMCB_CMD_FAULT_RECORD_WIPE;
         // pointer restarts on any other command, so each read sequence starts at byte 0
         if (cmd_rd && cmd_code == `PMCB_CMD_FAULT_RECORD_STREAM)
            log_ptr_r <= (log_ptr_r == `PMCB_LOG_LEN - 8'h01) ? 8'h00 : log_ptr_r + 8'h01;
         else if (cmd_rd || cmd_wr)
            log_ptr_r <= 8'h00;
      end
   end

   // read mux; paged reads on a bad page are flagged
   always @* begin
      rd_nxt = 16'h0000;
      rd_bad = 1'b0;
      case (cmd_code)
         `PMCB_CMD_CHANNEL_SELECT: rd_nxt = {8'h00, page_r};
         `PMCB_CMD_WRITE_LOCK_LEVEL: rd_nxt = {8'h00, wlock_r};
         `PMCB_CMD_CHANNEL_CONFIG_THREE: rd_nxt = {8'h00, cfg3_r};
         `PMCB_CMD_FAULT_RETRY_INTERVAL: rd_nxt = retry_r;
         `PMCB_CMD_CONTROL_RESTART_DELAY: rd_nxt = restart_r;
         `PMCB_CMD_OUTPUT_VOLTAGE_MAX: rd_nxt = vmax_r[pg];
         `PMCB_CMD_INPUT_VOLTAGE_MAX: rd_nxt = vin_max_r;
         `PMCB_CMD_EXT_TEMP_MAX: rd_nxt = tmax_r[pg];
         `PMCB_CMD_TRIM_CONVERTER_CODE: rd_nxt = trim_r[pg];
         `PMCB_CMD_PGOOD_ASSERT_DELAY: rd_nxt = pgood_r;
         `PMCB_CMD_WDOG_FIRST_INTERVAL: rd_nxt = wdf_r;
         `PMCB_CMD_WDOG_INTERVAL: rd_nxt = wdl_r;
         `PMCB_CMD_GLOBAL_PAGE_MASK: rd_nxt = {12'h000, mask_r}; // upper bits read zero
         `PMCB_CMD_PAD_STATE: rd_nxt = pads_r;
         `PMCB_CMD_BUS_ADDRESS_BASE: rd_nxt = {9'h000, base_r};
         `PMCB_CMD_PART_IDENTIFIER: rd_nxt = PART_ID;
         `PMCB_CMD_CONFIG_LOT_CODE: rd_nxt = {8'h00, lot_code};
         `PMCB_CMD_OFF_THRESHOLD_COEFF: rd_nxt = coeff_r[pg];
         `PMCB_CMD_FAULT_RECORD_STATE: rd_nxt = {14'h0000, log_locked, log_busy};
         `PMCB_CMD_FAULT_RECORD_STREAM: rd_nxt = {8'h00, log_rdata};
         `PMCB_CMD_SHARED_STATUS_BITS: rd_nxt = {8'h00, common_status};
         `PMCB_CMD_CURRENT_GAIN_TEMPCO: rd_nxt = tc_r[pg];
         `PMCB_CMD_FAULT_RETRY_LIMIT: rd_nxt = {8'h00, rlimit_r};
         `PMCB_CMD_EXT_TEMP_GAIN: rd_nxt = tgain_r[pg];
         `PMCB_CMD_EXT_TEMP_OFFSET: rd_nxt = toff_r[pg];
         `PMCB_CMD_CURRENT_SENSE_VOLTS: rd_nxt = isense_r[pg];
         `PMCB_CMD_OUTPUT_VOLTAGE_MIN: rd_nxt = vmin_r[pg];
         `PMCB_CMD_INPUT_VOLTAGE_MIN: rd_nxt = vin_min_r;
         `PMCB_CMD_EXT_TEMP_MIN: rd_nxt = tmin_r[pg];
         default: rd_bad = 1'b1;
      endcase
      case (cmd_code)
         `PMCB_CMD_OUTPUT_VOLTAGE_MAX, `PMCB_CMD_EXT_TEMP_MAX, `PMCB_CMD_TRIM_CONVERTER_CODE,
         `PMCB_CMD_OFF_THRESHOLD_COEFF, `PMCB_CMD_CURRENT_GAIN_TEMPCO, `PMCB_CMD_EXT_TEMP_GAIN,
         `PMCB_CMD_EXT_TEMP_OFFSET, `PMCB_CMD_CURRENT_SENSE_VOLTS, `PMCB_CMD_OUTPUT_VOLTAGE_MIN,
         `PMCB_CMD_EXT_TEMP_MIN: if (!page_ok) rd_bad = 1'b1;
         default: ;
      endcase
   end

   // answer registered one cycle after the request
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cmd_rdata <= 16'h0000;
         cmd_ack <= 1'b0;
         cmd_err <= 1'b0;
      end else begin
         cmd_ack <= cmd_rd | cmd_wr;
         cmd_err <= (cmd_rd && rd_bad) ||
                    (cmd_wr && (!wr_allow || (paged_cmd && !page_ok)));
         if (cmd_rd)
            cmd_rdata <= rd_bad ? 16'h0000 : rd_nxt;
      end
   end
endmodule // pmcb_bank
`default_nettype wire

// ### pmcb_defs.vh
// Purpose: command codes, reset values and field limits of the command bank
// Assumes: included by pmcb_bank.v
// Notes: definitions only
`ifndef PMCB_DEFS_VH
`define PMCB_DEFS_VH
`define PMCB_CMD_CHANNEL_SELECT 8'h00
`define PMCB_CMD_WRITE_LOCK_LEVEL 8'h10
`define PMCB_CMD_CHANNEL_CONFIG_THREE 8'hda
`define PMCB_CMD_FAULT_RETRY_INTERVAL 8'hdb
`define PMCB_CMD_CONTROL_RESTART_DELAY 8'hdc
`define PMCB_CMD_OUTPUT_VOLTAGE_MAX 8'hdd
`define PMCB_CMD_INPUT_VOLTAGE_MAX 8'hde
`define PMCB_CMD_EXT_TEMP_MAX 8'hdf
`define PMCB_CMD_TRIM_CONVERTER_CODE 8'he0
`define PMCB_CMD_PGOOD_ASSERT_DELAY 8'he1
`define PMCB_CMD_WDOG_FIRST_INTERVAL 8'he2
`define PMCB_CMD_WDOG_INTERVAL 8'he3
`define PMCB_CMD_GLOBAL_PAGE_MASK 8'he4
`define PMCB_CMD_PAD_STATE 8'he5
`define PMCB_CMD_BUS_ADDRESS_BASE 8'he6
`define PMCB_CMD_PART_IDENTIFIER 8'he7
`define PMCB_CMD_CONFIG_LOT_CODE 8'he8
`define PMCB_CMD_OFF_THRESHOLD_COEFF 8'he9
`define PMCB_CMD_FAULT_RECORD_SAVE 8'hea
`define PMCB_CMD_FAULT_RECORD_RELOAD 8'heb
`define PMCB_CMD_FAULT_RECORD_WIPE 8'hec
`define PMCB_CMD_FAULT_RECORD_STATE 8'hed
`define PMCB_CMD_FAULT_RECORD_STREAM 8'hee
`define PMCB_CMD_SHARED_STATUS_BITS 8'hef
`define PMCB_CMD_CURRENT_GAIN_TEMPCO 8'hf6
`define PMCB_CMD_FAULT_RETRY_LIMIT 8'hf7
`define PMCB_CMD_EXT_TEMP_GAIN 8'hf8
`define PMCB_CMD_EXT_TEMP_OFFSET 8'hf9
`define PMCB_CMD_CURRENT_SENSE_VOLTS 8'hfa
`define PMCB_CMD_OUTPUT_VOLTAGE_MIN 8'hfb
`define PMCB_CMD_INPUT_VOLTAGE_MIN 8'hfc
`define PMCB_CMD_EXT_TEMP_MIN 8'hfd
`define PMCB_RST_CHANNEL_SELECT 8'h00
`define PMCB_RST_WRITE_LOCK_LEVEL 8'h00
`define PMCB_RST_CHANNEL_CONFIG_THREE 8'h00
`define PMCB_RST_FAULT_RETRY_INTERVAL 16'hf320
`define PMCB_RST_CONTROL_RESTART_DELAY 16'hfb20
`define PMCB_RST_TRIM_CONVERTER_CODE 16'h0000
`define PMCB_RST_PGOOD_ASSERT_DELAY 16'heb20
`define PMCB_RST_WDOG_FIRST_INTERVAL 16'h8000
`define PMCB_RST_WDOG_INTERVAL 16'h8000
`define PMCB_RST_GLOBAL_PAGE_MASK 4'hf
`define PMCB_RST_BUS_ADDRESS_BASE 7'h5c
`define PMCB_RST_OFF_THRESHOLD_COEFF 16'hc200
`define PMCB_RST_CURRENT_GAIN_TEMPCO 16'h0000
`define PMCB_RST_FAULT_RETRY_LIMIT 8'h00
`define PMCB_RST_EXT_TEMP_GAIN 16'h4000
`define PMCB_RST_EXT_TEMP_OFFSET 16'h8000
`define PMCB_RST_MAX_TRACK 16'h0000
`define PMCB_RST_MIN_TRACK 16'hffff
`define PMCB_RST_SLIN_MAX 16'h7c00
`define PMCB_RST_SLIN_MIN 16'h7bff
`define PMCB_UNSIGNED_LINEAR_EXP 5'h13
`define PMCB_LOCK_LEVEL_ONE 8'h80
`define PMCB_LOCK_LEVEL_TWO 8'h40
`define PMCB_PAGE_GLOBAL 8'hff
`define PMCB_PAGE_LAST 8'h03
`define PMCB_TRIM_CODE_MASK 16'h03ff
`define PMCB_PART_ID_DEFAULT 16'h0a5a
`define PMCB_LOG_LEN 8'h10
`endif

// ### pmcb_log_store.sv
// Purpose: fault record store on the far side of the command bank
// Assumes: one clock shared with the bank
// Notes: starts locked so that a wipe has something to release
`timescale 1ns/1ps
`default_nettype none
module pmcb_log_store (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [7:0] log_raddr,
   input wire logic log_save,
   input wire logic log_reload,
   input wire logic log_wipe,
   output logic [7:0] log_rdata,
   output logic log_busy,
   output var logic log_locked
);
   logic [2:0] busy_cnt_r;
   // byte depends on the pointer, so a stuck or skipped pointer shows up
   assign log_rdata = log_raddr ^ 8'ha5;
   assign log_busy = busy_cnt_r != 3'd0;
   // every transfer keeps the store busy a while, like a slow nonvolatile write
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         busy_cnt_r <= 3'd0;
         log_locked <= 1'b1;
      end else begin
         if (log_save || log_reload || log_wipe)
            busy_cnt_r <= 3'd4;
         else if (log_busy)
            busy_cnt_r <= busy_cnt_r - 3'd1;
         if (log_wipe)
            log_locked <= 1'b0;
      end
   end
endmodule // pmcb_log_store
`default_nettype wire

// ### pmcb_bank_asserts.sv
// Purpose: port-level checks of the command bank
// Assumes: bound to pmcb_bank, one clock domain
// Notes: lock level is not visible here, so most relations run one way only
`timescale 1ns/1ps
`default_nettype none
module pmcb_bank_asserts (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   input wire logic [7:0] cmd_code,
   input wire logic [15:0] cmd_wdata,
   input wire logic cmd_ack,
   input wire logic cmd_err,
   input wire logic [7:0] log_raddr,
   input wire logic log_save,
   input wire logic log_reload,
   input wire logic log_wipe,
   input wire logic log_busy,
   input wire logic [1:0] page_sel,
   input wire logic page_global,
   input wire logic [3:0] global_write_en,
   input wire logic [15:0] retry_interval,
   input wire logic [15:0] restart_delay
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   sequence s_req; cmd_rd || cmd_wr; endsequence
   sequence s_page_wr; cmd_wr && cmd_code == 8'h00; endsequence
   property p_ack; s_req |=> cmd_ack; endproperty
   a_ack: assert property (p_ack) else $error("no ack after request");
   property p_err; cmd_err |-> cmd_ack; endproperty
   a_err: assert property (p_err) else $error("err without ack");
   property p_page; s_page_wr ##0 cmd_wdata[7:0] < 8'h04 |=>
      page_sel == $past(cmd_wdata[1:0]) && !page_global; endproperty
   a_page: assert property (p_page) else $error("page select wrong");
   property p_glob; s_page_wr ##0 cmd_wdata[7:0] == 8'hff |=> page_global; endproperty
   a_glob: assert property (p_glob) else $error("global page missed");
   property p_gmask; !page_global |-> global_write_en == 4'h0; endproperty
   a_gmask: assert property (p_gmask) else $error("global enable outside global page");
   // a changed word must come from a write of that code with that data
   property p_retry; $past(arst_n) && retry_interval != $past(retry_interval) |->
      $past(cmd_wr && cmd_code == 8'hdb) && retry_interval == $past(cmd_wdata); endproperty
   a_retry: assert property (p_retry) else $error("retry interval changed wrongly");
   property p_rst; $past(arst_n) && restart_delay != $past(restart_delay) |->
      $past(cmd_wr && cmd_code == 8'hdc) && restart_delay == $past(cmd_wdata); endproperty
   a_rst: assert property (p_rst) else $error("restart delay changed wrongly");
   property p_save; log_save |-> $past(cmd_wr && cmd_code == 8'hea && !log_busy); endproperty
   a_save: assert property (p_save) else $error("save strobe without cause");
   property p_load; log_reload |-> $past(cmd_wr && cmd_code == 8'heb && !log_busy); endproperty
   a_load: assert property (p_load) else $error("reload strobe without cause");
   property p_wipe; log_wipe |-> $past(cmd_wr && cmd_code == 8'hec && !log_busy); endproperty
   a_wipe: assert property (p_wipe) else $error("wipe strobe without cause");
   property p_strm; s_req ##0 cmd_code != 8'hee |=> log_raddr == 8'h00; endproperty
   a_strm: assert property (p_strm) else $error("record pointer not restarted");
endmodule // pmcb_bank_asserts
bind pmcb_bank pmcb_bank_asserts i_chk (.mclk, .arst_n, .cmd_wr, .cmd_rd, .cmd_code,
   .cmd_wdata, .cmd_ack, .cmd_err, .log_raddr, .log_save, .log_reload, .log_wipe,
   .log_busy, .page_sel, .page_global, .global_write_en, .retry_interval, .restart_delay);
`default_nettype wire

// ### tb_top.sv
// Purpose: self-checking bench of the command bank
// Assumes: log store partner answers the fault record side
// Notes: signed samples use exponent zero, so value order equals raw order
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [15:0] PID = 16'h1c3b; // arbitrary value
   logic mclk, arst_n, cmd_wr, cmd_rd, wp_pin, meas_vld, vin_vld, err_q;
   logic [1:0] meas_chan;
   logic [7:0] cmd_code, lot_code, common_status;
   logic [15:0] cmd_wdata, meas_vout, meas_temp, meas_isense, meas_vin, pad_in, rd_q, v, imax, imin;
   wire logic cmd_ack, cmd_err, log_save, log_reload, log_wipe, log_busy, log_locked, page_global;
   wire logic [1:0] page_sel;
   wire logic [3:0] global_write_en;
   wire logic [6:0] bus_addr_base;
   wire logic [7:0] log_rdata, log_raddr, retry_limit, config_three;
   wire logic [15:0] cmd_rdata, retry_interval, restart_delay, pgood_delay, wdog_first, wdog_later;
   int err_count, checks, n_save, n_reload;
   logic [31:0] seed = 32'h6dd2_e7d2;
   logic [15:0] vmax [4], vmin [4], tmax [4], tmin [4], isn [4], trim [4], wv [8];
   logic [7:0] rc [16] = '{8'h00, 8'h10, 8'hda, 8'hdb, 8'hdc, 8'he0, 8'he1, 8'he2,
      8'he3, 8'he4, 8'he6, 8'he9, 8'hf6, 8'hf7, 8'hf8, 8'hf9};
   logic [15:0] rv [16] = '{16'h0000, 16'h0000, 16'h0000, 16'hf320, 16'hfb20, 16'h0000,
      16'heb20, 16'h8000, 16'h8000, 16'h000f, 16'h005c, 16'hc200, 16'h0000, 16'h0000,
      16'h4000, 16'h8000};
   logic [7:0] wc [8] = '{8'hdb, 8'hdc, 8'he1, 8'he2, 8'he3, 8'hf7, 8'hda, 8'he6};

   pmcb_bank #(.PART_ID(PID)) i_dut (.mclk, .arst_n, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata,
      .wp_pin, .cmd_rdata, .cmd_ack, .cmd_err, .meas_vld, .meas_chan, .meas_vout, .meas_temp,
      .meas_isense, .vin_vld, .meas_vin, .pad_in, .lot_code, .common_status, .log_rdata,
      .log_raddr, .log_save, .log_reload, .log_wipe, .log_busy, .log_locked, .page_sel,
      .page_global, .global_write_en, .bus_addr_base, .retry_interval, .restart_delay,
      .pgood_delay, .wdog_first, .wdog_later, .retry_limit, .config_three);
   pmcb_log_store i_log (.mclk, .arst_n, .log_raddr, .log_save, .log_reload, .log_wipe,
      .log_rdata, .log_busy, .log_locked);

   function automatic logic [15:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction
   // bits kept by each writable code; narrow fields read back zero above
   function automatic logic [15:0] msk(input logic [7:0] c);
      case (c)
         8'he6: return 16'h007f;
         8'hf7, 8'hda: return 16'h00ff;
         default: return 16'hffff;
      endcase
   endfunction
   function automatic logic [15:0] port_of(input logic [7:0] c);
      case (c)
         8'hdb: return retry_interval;
         8'hdc: return restart_delay;
         8'he1: return pgood_delay;
         8'he2: return wdog_first;
         8'he3: return wdog_later;
         8'hf7: return {8'h00, retry_limit};
         8'hda: return {8'h00, config_three};
         default: return {9'h000, bus_addr_base};
      endcase
   endfunction
   task automatic give_verdict();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one request, held over the taking edge; the answer lands one cycle later
   task automatic bus(input logic wr, input logic [7:0] code, input logic [15:0] data);
      @(posedge mclk);
      #1;
      {cmd_wr, cmd_rd, cmd_code, cmd_wdata} = {wr, !wr, code, data};
      @(posedge mclk);
      #1;
      {cmd_wr, cmd_rd} = 2'b00;
      chk("cmd_ack", 16'h0001, {15'h0000, cmd_ack});
      if (cmd_ack !== 1'b1)
         give_verdict();
      rd_q = cmd_rdata;
      err_q = cmd_err;
   endtask
   task automatic rdc(input logic [7:0] code, input logic [15:0] exp);
      bus(1'b0, code, 16'h0000);
      chk($sformatf("read %h", code), exp, rd_q);
   endtask
   task automatic sample(input logic [1:0] c);
      logic [15:0] a, t, s, n;
      a = rnd();
      t = rnd() & 16'h03ff;
      s = rnd();
      n = rnd() & 16'h03ff;
      @(posedge mclk);
      #1;
      {meas_vld, vin_vld, meas_chan} = {2'b11, c};
      {meas_vout, meas_temp, meas_isense, meas_vin} = {a, t, s, n};
      @(posedge mclk);
      #1;
      {meas_vld, vin_vld} = 2'b00;
      if (a > vmax[c]) vmax[c] = a;
      if (a < vmin[c]) vmin[c] = a;
      if (t > tmax[c]) tmax[c] = t;
      if (t < tmin[c]) tmin[c] = t;
      if (n > imax) imax = n;
      if (n < imin) imin = n;
      isn[c] = s;
   endtask

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // counts of save and reload requests reaching the partner
   always @(posedge mclk) begin
      if (log_save === 1'b1) n_save++;
      if (log_reload === 1'b1) n_reload++;
   end
   initial begin
      {arst_n, cmd_wr, cmd_rd, wp_pin, meas_vld, vin_vld, meas_chan} = 8'h00;
      {cmd_code, cmd_wdata, meas_vout, meas_temp, meas_isense, meas_vin} = 88'h0;
      {lot_code, common_status, pad_in} = {rnd(), rnd()};
      {imax, imin} = {16'h0000, 16'h03ff};
      foreach (vmax[i]) {vmax[i], vmin[i], tmax[i], tmin[i]} = {32'h0000_ffff, 32'h0000_03ff};
      repeat (12) @(posedge mclk);
      #1 arst_n = 1'b1;
      foreach (rc[i]) rdc(rc[i], rv[i]);
      rdc(8'he7, PID);
      rdc(8'he8, {8'h00, lot_code});
      rdc(8'hef, {8'h00, common_status});
      rdc(8'he5, pad_in);
      foreach (wc[i]) begin
         v = rnd();
         wv[i] = v & msk(wc[i]);
         bus(1'b1, wc[i], v);
         chk("write err", 16'h0000, {15'h0000, err_q});
         rdc(wc[i], wv[i]);
         chk($sformatf("port %h", wc[i]), wv[i], port_of(wc[i]));
      end
      for (int p = 0; p < 4; p++) begin
         trim[p] = rnd();
         bus(1'b1, 8'h00, 16'(p));
         bus(1'b1, 8'he0, trim[p]);
      end
      for (int p = 3; p >= 0; p--) begin
         bus(1'b1, 8'h00, 16'(p));
         chk("page_sel", 16'(p), {14'h0000, page_sel});
         rdc(8'he0, trim[p] & 16'h03ff);
      end
      bus(1'b1, 8'h00, 16'h0005);
      bus(1'b1, 8'he0, 16'h0001);
      chk("bad page write err", 16'h0001, {15'h0000, err_q});
      rdc(8'he0, 16'h0000);
      chk("bad page read err", 16'h0001, {15'h0000, err_q});
      v = rnd() & 16'h00ff;
      bus(1'b1, 8'he4, v);
      rdc(8'he4, v & 16'h000f);
      bus(1'b1, 8'h00, 16'h00ff);
      chk("global mask", v & 16'h000f, {12'h000, global_write_en});
      chk("page_global", 16'h0001, {15'h0000, page_global});
      for (int i = 0; i < 8; i++) sample(2'(1 + i % 2));
      for (int p = 1; p < 3; p++) begin
         bus(1'b1, 8'h00, 16'(p));
         rdc(8'hdd, vmax[p]);
         rdc(8'hfb, vmin[p]);
         rdc(8'hdf, tmax[p]);
         rdc(8'hfd, tmin[p]);
         rdc(8'hfa, isn[p]);
      end
      rdc(8'hde, imax);
      rdc(8'hfc, imin);
      bus(1'b0, 8'hed, 16'h0000);
      chk("record state", 16'h0002, rd_q & 16'h0003);
      bus(1'b1, 8'hea, 16'h0000);
      bus(1'b1, 8'hea, 16'h0000);
      repeat (8) @(posedge mclk);
      bus(1'b1, 8'heb, 16'h0000);
      repeat (8) @(posedge mclk);
      chk("save count", 16'h0001, 16'(n_save));
      chk("reload count", 16'h0001, 16'(n_reload));
      bus(1'b1, 8'hec, 16'h0000);
      repeat (8) @(posedge mclk);
      bus(1'b0, 8'hed, 16'h0000);
      chk("record state", 16'h0000, rd_q & 16'h0003);
      for (int i = 0; i < 17; i++) begin
         bus(1'b0, 8'hee, 16'h0000);
         chk("record byte", {8'h00, 8'(i % 16) ^ 8'ha5}, rd_q & 16'h00ff);
      end
      bus(1'b1, 8'h10, 16'h0080);
      bus(1'b1, 8'hdb, rnd());
      chk("lock write err", 16'h0001, {15'h0000, err_q});
      rdc(8'hdb, wv[0]);
      bus(1'b1, 8'h10, 16'h0000);
      wp_pin = 1'b1;
      bus(1'b1, 8'he4, 16'h0003);
      chk("pin mask write err", 16'h0000, {15'h0000, err_q});
      bus(1'b1, 8'hdc, rnd());
      chk("pin write err", 16'h0001, {15'h0000, err_q});
      wp_pin = 1'b0;
      rdc(8'hdc, wv[1]);
      rdc(8'he4, 16'h0003);
      bus(1'b0, 8'h20, 16'h0000);
      chk("unmapped err", 16'h0001, {15'h0000, err_q});
      give_verdict();
   end
endmodule // tb_top
`default_nettype wire
